// file: uart_regs_pkg.sv
// Offsets, field positions, reset values and timing shared by the serial port files
`default_nettype none
package uart_regs_pkg;
	// ==========================================
	// Register offsets
	localparam logic [11:0] OFF_CONTROL_A = 12'h280;
	localparam logic [11:0] OFF_CONTROL_B = 12'h282;
	localparam logic [11:0] OFF_STATUS = 12'h284;
	localparam logic [11:0] OFF_MASK = 12'h286;
	localparam logic [11:0] OFF_TX_HOLD = 12'h288;
	localparam logic [11:0] OFF_RX_BUF = 12'h28a;
	localparam logic [11:0] OFF_IRQ_CH11 = 12'h290;
	// ==========================================
	// Status and mask bit positions
	localparam int ST_IDLE = 0;
	localparam int ST_QUIET_LINE_PENDING_DATA = 1;
	localparam int ST_TX_FULLY_DRAINED = 2;
	localparam int ST_PER = 3;
	localparam int ST_OER = 4;
	localparam int ST_FER = 5;
	localparam int ST_TX_HOLDING_EMPTY = 6;
	localparam int ST_RDR = 7;
	localparam int ST_AB = 8;
	localparam int ST_BRK = 9;
	localparam logic [9:0] MASK_RESET = 10'h2f8;
	localparam logic [9:0] SW_CLEARABLE = 10'h33a;
	localparam logic [9:0] GRP_RX_STATUS = 10'h339;
	localparam logic [9:0] GRP_RX_DATA = 10'h082;
	localparam logic [9:0] GRP_TX = 10'h044;
	// ==========================================
	// Control A, control B and channel eleven fields
	localparam int CA_TWO_STOP = 0;
	localparam int CA_PAR_EN = 1;
	localparam int CA_PAR_EVEN = 2;
	localparam int CA_ADDR_EN = 3;
	localparam int CA_RX_DATA_GROUP_ENABLE = 7;
	localparam int CA_TX_GROUP_ENABLE = 8;
	localparam int CA_AB = 10;
	localparam int CA_BRK = 11;
	localparam int CA_RX_STATUS_GROUP_ENABLE = 12;
	localparam logic [15:0] CA_WMASK = 16'h1d8f;
	localparam int CB_EXTENDED_READ_MODE = 1;
	localparam int CB_EXTENDED_WRITE_MODE = 2;
	localparam int CB_BRKVAL = 3;
	localparam logic [15:0] CB_WMASK = 16'h000e;
	localparam int CH_ENABLE = 0;
	localparam int CH_SRC_UART = 1;
	// ==========================================
	// Receive buffer extended view and transmit fields
	localparam int RB_AB = 8;
	localparam int RB_BRK = 9;
	localparam int RB_PER = 11;
	localparam int RB_OER = 12;
	localparam int RB_FER = 13;
	localparam int RB_TX_HOLDING_EMPTY = 14;
	localparam int RB_RDR = 15;
	localparam int TX_AB = 8;
	// ==========================================
	// Timing
	localparam int CLOCK_HZ = 25_000_000;
	localparam int BAUD_HZ = 9600;
	localparam int OVERSAMPLE = 16;
	localparam int SAMPLE_DIV = CLOCK_HZ / (BAUD_HZ * OVERSAMPLE);
	localparam int IDLE_BIT_TIMES = 40;
	localparam logic [9:0] IDLE_TICKS = 10'(IDLE_BIT_TIMES * OVERSAMPLE);
	localparam logic [3:0] HALF_BIT = 4'(OVERSAMPLE / 2 - 1);
	localparam logic [3:0] LAST_TICK = 4'(OVERSAMPLE - 1);
	localparam logic [3:0] CHAR_BITS = 4'h8;
	// One received frame with its own status
	typedef struct packed {
		logic break_flag;
		logic ab;
		logic parity_flag;
		logic overrun_flag;
		logic framing_err_flag;
		logic [7:0] data;
	} rx_entry_t;
endpackage
`default_nettype wire

// file: uart_lane_if.sv
// Signals between the register core and the line receiver and transmitter
`timescale 1ns/10ps
`default_nettype none
interface uart_lane_if;
	logic sample_tick;
	logic parity_en;
	logic parity_even;
	logic addr_en;
	logic two_stop;
	logic send_break;
	logic break_value;
	logic frame_done;
	logic [7:0] rx_char;
	logic rx_addr;
	logic rx_perr;
	logic rx_ferr;
	logic rx_brk;
	logic in_frame;
	logic line_high;
	logic load_req;
	logic [8:0] load_word;
	logic load_ack;
	logic tx_busy;
	logic txd;
	modport core (output sample_tick, parity_en, parity_even, addr_en, two_stop, send_break,
		break_value, load_req, load_word, input frame_done, rx_char, rx_addr, rx_perr,
		rx_ferr, rx_brk, in_frame, line_high, load_ack, tx_busy, txd);
	modport rx (input sample_tick, parity_en, parity_even, addr_en, output frame_done,
		rx_char, rx_addr, rx_perr, rx_ferr, rx_brk, in_frame, line_high);
	modport tx (input sample_tick, parity_en, parity_even, addr_en, two_stop, send_break,
		break_value, load_req, load_word, output load_ack, tx_busy, txd);
endinterface
`default_nettype wire

// file: uart_line_receiver.sv
// Receive line synchroniser and frame receiver
`timescale 1ns/10ps
`default_nettype none
module uart_line_receiver (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic rxd,
	uart_lane_if.rx lane
);
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} rx_state_t;
	rx_state_t state_q, state_d;
	logic s1_q, s2_q, s3_q, level_q, level_d, pbit;
	logic [3:0] tick_q, tick_d, idx_q, idx_d, nbits;
	logic [9:0] shift_q, shift_d;
	uart_regs_pkg::rx_entry_t out_q, out_d;
	logic done_q, done_d;

	assign lane.frame_done = done_q;
	assign lane.rx_char = out_q.data;
	assign lane.rx_addr = out_q.ab;
	assign lane.rx_perr = out_q.parity_flag;
	assign lane.rx_ferr = out_q.framing_err_flag;
	assign lane.rx_brk = out_q.break_flag;
	assign lane.in_frame = (state_q != RX_IDLE);
	assign lane.line_high = level_q;

	// ==========================================
	// Frame sequencer, sampling mid-bit on the oversample enable
	always_comb begin
		level_d = (s2_q == s3_q) ? s3_q : level_q;
		state_d = state_q;
		tick_d = tick_q;
		idx_d = idx_q;
		shift_d = shift_q;
		out_d = out_q;
		done_d = 1'b0;
		nbits = uart_regs_pkg::CHAR_BITS + {3'b000, lane.addr_en} + {3'b000, lane.parity_en};
		pbit = lane.addr_en ? shift_q[9] : shift_q[8];
		unique case (state_q)
			RX_IDLE: if (!level_q) begin
				state_d = RX_START;
				tick_d = 4'h0;
			end
			RX_START: if (lane.sample_tick) begin
				tick_d = tick_q + 4'h1;
				if (tick_q == uart_regs_pkg::HALF_BIT) begin
					// A glitch shorter than half a bit is not a start bit
					tick_d = 4'h0;
					idx_d = 4'h0;
					shift_d = 10'h000;
					state_d = level_q ? RX_IDLE : RX_BITS;
				end
			end
			RX_BITS: if (lane.sample_tick) begin
				tick_d = tick_q + 4'h1;
				if (tick_q == uart_regs_pkg::LAST_TICK) begin
					shift_d[idx_q] = level_q;
					idx_d = idx_q + 4'h1;
					if (idx_q == nbits - 4'h1) begin
						state_d = RX_STOP;
					end
				end
			end
			RX_STOP: if (lane.sample_tick) begin
				tick_d = tick_q + 4'h1;
				if (tick_q == uart_regs_pkg::LAST_TICK) begin
					done_d = 1'b1;
					out_d.data = shift_q[7:0];
					out_d.ab = lane.addr_en & shift_q[8];
					out_d.parity_flag = lane.parity_en & (^shift_q[7:0] ^ pbit ^ ~lane.parity_even);
					out_d.framing_err_flag = ~level_q;
					out_d.break_flag = ~level_q & (shift_q == 10'h000);
					out_d.overrun_flag = 1'b0;
					state_d = RX_IDLE;
				end
			end
		endcase
	end

	// Registers; the first sync stage feeds only the second
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			s1_q <= 1'b1;
			s2_q <= 1'b1;
			s3_q <= 1'b1;
			level_q <= 1'b1;
			state_q <= RX_IDLE;
			tick_q <= 4'h0;
			idx_q <= 4'h0;
			shift_q <= 10'h000;
			out_q <= '0;
			done_q <= 1'b0;
		end else begin
			s1_q <= rxd;
			s2_q <= s1_q;
			s3_q <= s2_q;
			level_q <= level_d;
			state_q <= state_d;
			tick_q <= tick_d;
			idx_q <= idx_d;
			shift_q <= shift_d;
			out_q <= out_d;
			done_q <= done_d;
		end
	end
endmodule
`default_nettype wire

// file: uart_line_transmitter.sv
// Transmit shift register and line driver
`timescale 1ns/10ps
`default_nettype none
module uart_line_transmitter (
	input wire logic clock,
	input wire logic reset_n,
	uart_lane_if.tx lane
);
	typedef enum logic {TX_IDLE, TX_SEND} tx_state_t;
	tx_state_t state_q, state_d;
	logic [12:0] frame_q, frame_d;
	logic [3:0] left_q, left_d, tick_q, tick_d, pos;
	logic txd_q, txd_d, ack;

	assign lane.load_ack = ack;
	assign lane.tx_busy = (state_q == TX_SEND);
	assign lane.txd = txd_q;

	// ==========================================
	// Frame builder and bit shifter
	always_comb begin
		state_d = state_q;
		frame_d = frame_q;
		left_d = left_q;
		tick_d = tick_q;
		ack = 1'b0;
		pos = 4'h9;
		unique case (state_q)
			TX_IDLE: if (lane.load_req) begin
				ack = 1'b1;
				frame_d = 13'h1fff;
				frame_d[8:0] = {lane.load_word[7:0], 1'b0};
				if (lane.addr_en) begin
					frame_d[pos] = lane.load_word[8];
					pos = pos + 4'h1;
				end
				if (lane.parity_en) begin
					frame_d[pos] = ^lane.load_word[7:0] ^ ~lane.parity_even;
					pos = pos + 4'h1;
				end
				left_d = pos + 4'h1 + {3'b000, lane.two_stop};
				tick_d = 4'h0;
				state_d = TX_SEND;
			end
			TX_SEND: if (lane.sample_tick) begin
				tick_d = tick_q + 4'h1;
				if (tick_q == uart_regs_pkg::LAST_TICK) begin
					frame_d = {1'b1, frame_q[12:1]};
					left_d = left_q - 4'h1;
					if (left_q == 4'h1) begin
						state_d = TX_IDLE;
					end
				end
			end
		endcase
		// Break overrides the line at any point of a frame
		txd_d = lane.send_break ? lane.break_value : ((state_d == TX_SEND) ? frame_d[0] : 1'b1);
	end

	// Registers
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			state_q <= TX_IDLE;
			frame_q <= 13'h1fff;
			left_q <= 4'h0;
			tick_q <= 4'h0;
			txd_q <= 1'b1;
		end else begin
			state_q <= state_d;
			frame_q <= frame_d;
			left_q <= left_d;
			tick_q <= tick_d;
			txd_q <= txd_d;
		end
	end
endmodule
`default_nettype wire

// file: uart_irq_mask_and_data_regs.sv
// Register core of the serial port: status, mask, transmit holding and receive buffer
//
// Chosen here: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Set idle-with-data flag after 40 quiet bits
// - Idle-with-data flag cleared only by software
// - Line idle flag low while in frame
// - Mask bits nine..zero gate matching status flags
// - Three group enables gate their sources
// - Rx status interrupt blocks DMA unless extended
// - Interrupt leaves only via enabled channel eleven
// - Late transmit write overwrites, shifter untouched
// - Transmit: char low byte, address bit eight
// - Address bit writable only in extended write
// - Extended read shows status in upper byte
// - Frame fields valid only while data ready
// - Buffer read clears ready unless more waiting
// - Framing checked on first stop bit only
// - Upper byte zero without extended read
// - Overrun set on lost data, software clears
module uart_irq_mask_and_data_regs #(
	parameter int SAMPLE_DIV = uart_regs_pkg::SAMPLE_DIV
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [11:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [15:0] reg_rdata,
	input wire logic rxd,
	output logic txd,
	output logic irq_req,
	output logic rx_dma_req
);
	uart_lane_if lane ();

	logic [15:0] ctl_a_q, ctl_a_d, ctl_b_q, ctl_b_d;
	logic [1:0] ch11_q, ch11_d;
	logic [9:0] mask_q, mask_d, flags_q, flags_d, sets, clears, status, groups, pending;
	logic rdr_q, rdr_d, pend_full_q, pend_full_d, hold_full_q, hold_full_d;
	uart_regs_pkg::rx_entry_t cur_q, cur_d, pend_q, pend_d, arrived;
	logic [8:0] hold_q, hold_d;
	logic [15:0] div_q, div_d, rdata_q, rdata_d, rxbuf_view;
	logic [9:0] quiet_q, quiet_d;
	logic tick_q, tick_d, quiet_hit, irq_q, irq_d, dma_q, dma_d;
	logic wr_ctl_a, wr_ctl_b, wr_status, wr_mask, wr_tx, wr_ch11, rd_rx;
	logic extended_read_mode, extended_write_mode;

	// ==========================================
	// Address decode and configuration fan-out
	assign wr_ctl_a = reg_write && (reg_addr == uart_regs_pkg::OFF_CONTROL_A);
	assign wr_ctl_b = reg_write && (reg_addr == uart_regs_pkg::OFF_CONTROL_B);
	assign wr_status = reg_write && (reg_addr == uart_regs_pkg::OFF_STATUS);
	assign wr_mask = reg_write && (reg_addr == uart_regs_pkg::OFF_MASK);
	assign wr_tx = reg_write && (reg_addr == uart_regs_pkg::OFF_TX_HOLD);
	assign wr_ch11 = reg_write && (reg_addr == uart_regs_pkg::OFF_IRQ_CH11);
	assign rd_rx = reg_read && (reg_addr == uart_regs_pkg::OFF_RX_BUF);
	assign extended_read_mode = ctl_b_q[uart_regs_pkg::CB_EXTENDED_READ_MODE];
	assign extended_write_mode = ctl_b_q[uart_regs_pkg::CB_EXTENDED_WRITE_MODE];

	// Line-side configuration comes straight from control registers
	assign lane.sample_tick = tick_q;
	assign lane.parity_en = ctl_a_q[uart_regs_pkg::CA_PAR_EN];
	assign lane.parity_even = ctl_a_q[uart_regs_pkg::CA_PAR_EVEN];
	assign lane.addr_en = ctl_a_q[uart_regs_pkg::CA_ADDR_EN];
	assign lane.two_stop = ctl_a_q[uart_regs_pkg::CA_TWO_STOP];
	assign lane.send_break = ctl_a_q[uart_regs_pkg::CA_BRK];
	assign lane.break_value = ctl_b_q[uart_regs_pkg::CB_BRKVAL];
	assign lane.load_req = hold_full_q;
	assign lane.load_word = hold_q;

	// Top outputs, each from a flop
	assign reg_rdata = rdata_q;
	assign txd = lane.txd;
	assign irq_req = irq_q;
	assign rx_dma_req = dma_q;

	uart_line_receiver rx_unit (
		.clock(clock),
		.reset_n(reset_n),
		.rxd(rxd),
		.lane(lane.rx)
	);

	uart_line_transmitter tx_unit (
		.clock(clock),
		.reset_n(reset_n),
		.lane(lane.tx)
	);

	// ==========================================
	// Oversample divider and quiet-line timer
	// A divider of one makes every clock a sample tick, which keeps sims short
	always_comb begin
		div_d = div_q + 16'h0001;
		tick_d = 1'b0;
		if (div_q == 16'(SAMPLE_DIV - 1)) begin
			div_d = 16'h0000;
			tick_d = 1'b1;
		end
		quiet_d = quiet_q;
		quiet_hit = 1'b0;
		if (lane.in_frame || !lane.line_high) begin
			quiet_d = 10'h000;
		end else if (tick_q && (quiet_q != uart_regs_pkg::IDLE_TICKS)) begin
			quiet_d = quiet_q + 10'h001;
			quiet_hit = (quiet_q == uart_regs_pkg::IDLE_TICKS - 10'h001);
		end
	end

	// ==========================================
	// Status assembly, live bits merged with sticky ones
	always_comb begin
		status = flags_q & uart_regs_pkg::SW_CLEARABLE;
		status[uart_regs_pkg::ST_IDLE] = ~lane.in_frame;
		status[uart_regs_pkg::ST_RDR] = rdr_q;
		status[uart_regs_pkg::ST_TX_HOLDING_EMPTY] = ~hold_full_q;
		status[uart_regs_pkg::ST_TX_FULLY_DRAINED] = ~hold_full_q & ~lane.tx_busy;
		groups = 10'h000;
		if (ctl_a_q[uart_regs_pkg::CA_RX_STATUS_GROUP_ENABLE]) begin
			groups = groups | uart_regs_pkg::GRP_RX_STATUS;
		end
		if (ctl_a_q[uart_regs_pkg::CA_RX_DATA_GROUP_ENABLE]) begin
			groups = groups | uart_regs_pkg::GRP_RX_DATA;
		end
		if (ctl_a_q[uart_regs_pkg::CA_TX_GROUP_ENABLE]) begin
			groups = groups | uart_regs_pkg::GRP_TX;
		end
		pending = status & mask_q & groups;
		irq_d = (|pending) && ch11_q[uart_regs_pkg::CH_ENABLE]
			&& ch11_q[uart_regs_pkg::CH_SRC_UART];
		dma_d = rdr_q && !(!extended_read_mode && (|(pending & uart_regs_pkg::GRP_RX_STATUS)));
	end

	// ==========================================
	// Register state: receive queue, sticky flags, transmit holding
	always_comb begin
		ctl_a_d = ctl_a_q;
		ctl_b_d = ctl_b_q;
		ch11_d = ch11_q;
		mask_d = mask_q;
		rdr_d = rdr_q;
		cur_d = cur_q;
		pend_d = pend_q;
		pend_full_d = pend_full_q;
		hold_d = hold_q;
		hold_full_d = hold_full_q;
		sets = 10'h000;
		arrived = '0;
		arrived.data = lane.rx_char;
		arrived.ab = lane.rx_addr;
		arrived.parity_flag = lane.rx_perr;
		arrived.framing_err_flag = lane.rx_ferr;
		arrived.break_flag = lane.rx_brk;
		if (rd_rx) begin
			if (pend_full_q) begin
				cur_d = pend_q;
				pend_full_d = 1'b0;
			end else begin
				rdr_d = 1'b0;
			end
		end
		// A frame landing during the read goes behind it, so nothing is dropped
		if (lane.frame_done) begin
			sets[uart_regs_pkg::ST_PER] = lane.rx_perr;
			sets[uart_regs_pkg::ST_FER] = lane.rx_ferr;
			sets[uart_regs_pkg::ST_BRK] = lane.rx_brk;
			sets[uart_regs_pkg::ST_AB] = lane.rx_addr;
			if (!rdr_d) begin
				cur_d = arrived;
				rdr_d = 1'b1;
			end else if (!pend_full_d) begin
				pend_d = arrived;
				pend_full_d = 1'b1;
			end else begin
				pend_d = arrived;
				pend_d.overrun_flag = 1'b1;
				sets[uart_regs_pkg::ST_OER] = 1'b1;
			end
		end
		sets[uart_regs_pkg::ST_QUIET_LINE_PENDING_DATA] = quiet_hit && rdr_q;
		clears = wr_status ? (~reg_wdata[9:0] & uart_regs_pkg::SW_CLEARABLE) : 10'h000;
		flags_d = ((flags_q & ~clears) | sets) & uart_regs_pkg::SW_CLEARABLE;
		// Shifter took the word; the control address bit is spent
		if (lane.load_ack) begin
			hold_full_d = 1'b0;
			ctl_a_d[uart_regs_pkg::CA_AB] = 1'b0;
		end
		if (wr_ctl_a) begin
			ctl_a_d = reg_wdata & uart_regs_pkg::CA_WMASK;
		end
		if (wr_ctl_b) begin
			ctl_b_d = reg_wdata & uart_regs_pkg::CB_WMASK;
		end
		if (wr_mask) begin
			mask_d = reg_wdata[9:0];
		end
		if (wr_ch11) begin
			ch11_d = reg_wdata[1:0];
		end
		if (wr_tx) begin
			hold_d[7:0] = reg_wdata[7:0];
			hold_d[uart_regs_pkg::TX_AB] = extended_write_mode ? reg_wdata[uart_regs_pkg::TX_AB]
				: ctl_a_q[uart_regs_pkg::CA_AB];
			hold_full_d = 1'b1;
		end
	end

	// ==========================================
	// Read data, present only in the cycle after the strobe
	// Unmapped offsets read as zero, so a stray probe leaves no state behind
	always_comb begin
		rxbuf_view = {8'h00, cur_q.data};
		if (extended_read_mode) begin
			rxbuf_view[uart_regs_pkg::RB_RDR] = rdr_q;
			rxbuf_view[uart_regs_pkg::RB_TX_HOLDING_EMPTY] = ~hold_full_q;
			if (rdr_q) begin
				rxbuf_view[uart_regs_pkg::RB_FER] = cur_q.framing_err_flag;
				rxbuf_view[uart_regs_pkg::RB_OER] = cur_q.overrun_flag;
				rxbuf_view[uart_regs_pkg::RB_PER] = cur_q.parity_flag;
				rxbuf_view[uart_regs_pkg::RB_BRK] = cur_q.break_flag;
				rxbuf_view[uart_regs_pkg::RB_AB] = cur_q.ab;
			end
		end
		rdata_d = 16'h0000;
		if (reg_read) begin
			case (reg_addr)
				uart_regs_pkg::OFF_CONTROL_A: rdata_d = ctl_a_q;
				uart_regs_pkg::OFF_CONTROL_B: rdata_d = ctl_b_q;
				uart_regs_pkg::OFF_STATUS: rdata_d = {6'h00, status};
				uart_regs_pkg::OFF_MASK: rdata_d = {6'h00, mask_q};
				uart_regs_pkg::OFF_TX_HOLD: rdata_d = {7'h00, hold_q};
				uart_regs_pkg::OFF_RX_BUF: rdata_d = rxbuf_view;
				uart_regs_pkg::OFF_IRQ_CH11: rdata_d = {14'h0000, ch11_q};
				default: rdata_d = 16'h0000;
			endcase
		end
	end

	// ==========================================
	// All core flops
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			ctl_a_q <= 16'h0000;
			ctl_b_q <= 16'h0000;
			ch11_q <= 2'h0;
			mask_q <= uart_regs_pkg::MASK_RESET;
			flags_q <= 10'h000;
			rdr_q <= 1'b0;
			cur_q <= '0;
			pend_q <= '0;
			pend_full_q <= 1'b0;
			hold_q <= 9'h000;
			hold_full_q <= 1'b0;
			div_q <= 16'h0000;
			tick_q <= 1'b0;
			quiet_q <= 10'h000;
			rdata_q <= 16'h0000;
			irq_q <= 1'b0;
			dma_q <= 1'b0;
		end else begin
			ctl_a_q <= ctl_a_d;
			ctl_b_q <= ctl_b_d;
			ch11_q <= ch11_d;
			mask_q <= mask_d;
			flags_q <= flags_d;
			rdr_q <= rdr_d;
			cur_q <= cur_d;
			pend_q <= pend_d;
			pend_full_q <= pend_full_d;
			hold_q <= hold_d;
			hold_full_q <= hold_full_d;
			div_q <= div_d;
			tick_q <= tick_d;
			quiet_q <= quiet_d;
			rdata_q <= rdata_d;
			irq_q <= irq_d;
			dma_q <= dma_d;
		end
	end
endmodule
`default_nettype wire

// file: uart_regs_properties.sv
// Checker for the serial port register core, seen from its top ports
`timescale 1ns/10ps
`default_nettype none
module uart_regs_properties #(
	parameter int SAMPLE_DIV = 1
) (
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [11:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [15:0] reg_rdata,
	input wire logic rxd,
	input wire logic txd,
	input wire logic irq_req,
	input wire logic rx_dma_req
);
	// ==========================================
	// Shadows of the writable controls
	logic [9:0] mask_q, mask_d;
	logic [2:0] grp_q, grp_d;
	logic [1:0] ch_q, ch_d;
	logic ext_q, ext_d, ch_on, m_off, g_off;
	// Next values, taken only from whole register writes
	assign mask_d = (reg_write && reg_addr == 12'h286) ? reg_wdata[9:0] : mask_q;
	assign grp_d = (reg_write && reg_addr == 12'h280) ? {reg_wdata[12], reg_wdata[8:7]} : grp_q;
	assign ext_d = (reg_write && reg_addr == 12'h282) ? reg_wdata[1] : ext_q;
	assign ch_d = (reg_write && reg_addr == 12'h290) ? reg_wdata[1:0] : ch_q;
	assign ch_on = &ch_q;
	assign m_off = mask_q == 10'h000;
	assign g_off = grp_q == 3'h0;
	// Registers only; irq lags a write by two edges, hence the three-cycle windows
	always_ff @(posedge clock) begin
		if (!reset_n) begin
			mask_q <= uart_regs_pkg::MASK_RESET;
			grp_q <= 3'h0;
			ext_q <= 1'b0;
			ch_q <= 2'h0;
		end else begin
			mask_q <= mask_d;
			grp_q <= grp_d;
			ext_q <= ext_d;
			ch_q <= ch_d;
		end
	end
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	// ==========================================
	// Register views
	property p_mask_rb;
		reg_read && reg_addr == 12'h286 |=> reg_rdata == {6'h00, $past(mask_q)};
	endproperty
	a_mask_rb: assert property (p_mask_rb) else $error("mask readback wrong");
	property p_tx_rsvd;
		reg_read && reg_addr == 12'h288 |=> reg_rdata[15:9] == 7'h00;
	endproperty
	a_tx_rsvd: assert property (p_tx_rsvd) else $error("transmit reserved bits set");
	property p_rx_narrow;
		reg_read && reg_addr == 12'h28a && !ext_q |=> reg_rdata[15:8] == 8'h00;
	endproperty
	a_rx_narrow: assert property (p_rx_narrow) else $error("upper byte not zero");
	property p_rx_res;
		reg_read && reg_addr == 12'h28a && ext_q |=> !reg_rdata[10];
	endproperty
	a_rx_res: assert property (p_rx_res) else $error("reserved bit ten set");
	property p_rx_void;
		reg_read && reg_addr == 12'h28a && ext_q ##1 !reg_rdata[15]
			|-> reg_rdata[13:11] == 3'h0 && reg_rdata[9:8] == 2'h0;
	endproperty
	a_rx_void: assert property (p_rx_void) else $error("status shown without data");
	// ==========================================
	// Interrupt gating
	property p_ch_off;
		!ch_on && !$past(ch_on) && !$past(ch_on, 2) |-> !irq_req;
	endproperty
	a_ch_off: assert property (p_ch_off) else $error("irq with channel off");
	property p_mask_off;
		m_off && $past(m_off) && $past(m_off, 2) |-> !irq_req;
	endproperty
	a_mask_off: assert property (p_mask_off) else $error("irq with mask clear");
	property p_grp_off;
		g_off && $past(g_off) && $past(g_off, 2) |-> !irq_req;
	endproperty
	a_grp_off: assert property (p_grp_off) else $error("irq with groups off");
endmodule
bind uart_irq_mask_and_data_regs uart_regs_properties #(.SAMPLE_DIV(SAMPLE_DIV)) u_props (
	.clock(clock), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .rxd(rxd),
	.txd(txd), .irq_req(irq_req), .rx_dma_req(rx_dma_req));
`default_nettype wire

// file: uart_far_end.sv
// Far-end serial station: drives the receive pin, collects the transmit pin
`timescale 1ns/10ps
`default_nettype none
module uart_far_end #(
	parameter int BIT_CLKS = 16
) (
	input wire logic clock,
	output logic line_out,
	input wire logic line_in
);
	logic [7:0] got[$];
	logic [7:0] sh;
	// Idle line is high, like a pulled-up pin
	initial line_out = 1'b1;
	// One frame, LSB first; a low stop bit makes a framing fault
	task automatic send_frame(input logic [7:0] b, input logic stop_ok);
		logic [9:0] f;
		f = {stop_ok, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clock);
			line_out <= f[i];
			repeat (BIT_CLKS - 1) @(posedge clock);
		end
		@(posedge clock);
		line_out <= 1'b1;
	endtask
	// Mid-bit sampling of the transmit pin
	initial begin
		forever begin
			@(negedge line_in);
			repeat (BIT_CLKS / 2) @(posedge clock);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CLKS) @(posedge clock);
				sh[i] = line_in;
			end
			repeat (BIT_CLKS) @(posedge clock);
			got.push_back(sh);
		end
	end
endmodule
`default_nettype wire

// file: test_uart_irq_mask_and_data_regs.sv
// Self-checking bench for the serial port register core
`timescale 1ns/10ps
`default_nettype none
`define check_eq(a, e) begin compares++; if ((a) !== (e)) begin n_fail++; \
	$display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_uart_irq_mask_and_data_regs;
	localparam int DIV = 1;
	logic clock, reset_n, reg_write, reg_read, rxd, txd, irq_req, rx_dma_req;
	logic [11:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata, v;
	int n_fail = 0;
	int compares = 0;
	uart_irq_mask_and_data_regs #(.SAMPLE_DIV(DIV)) u_dut (.clock(clock), .reset_n(reset_n),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
		.reg_read(reg_read), .reg_rdata(reg_rdata), .rxd(rxd), .txd(txd),
		.irq_req(irq_req), .rx_dma_req(rx_dma_req));
	uart_far_end #(.BIT_CLKS(16 * DIV)) u_peer (.clock(clock), .line_out(rxd), .line_in(txd));
	// ==========================================
	// Clock, bus tasks and verdict
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
	endtask
	// Read data stands only in the cycle after the strobe
	task automatic rd(input logic [11:0] a);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 v = reg_rdata;
	endtask
	task automatic rdc(input logic [11:0] a, input logic [15:0] e);
		rd(a);
		`check_eq(v, e)
	endtask
	task automatic waitc(input int n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task automatic wrap_up();
		$display("compares=%0d n_fail=%0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// Watchdog, far beyond the few thousand cycles the tests need
	initial begin
		repeat (20000) @(posedge clock);
		n_fail++;
		wrap_up();
	end
	// ==========================================
	// Tests
	initial begin
		reset_n = 1'b0;
		reg_write = 1'b0;
		reg_read = 1'b0;
		reg_addr = 12'h000;
		reg_wdata = 16'h0000;
		repeat (3) @(posedge clock);
		reset_n <= 1'b1;
		// Reset values, unmapped place, read-only buffer, mask bits
		rdc(12'h286, 16'h02f8);
		rdc(12'h288, 16'h0000);
		rdc(12'h28a, 16'h0000);
		rdc(12'h2a0, 16'h0000);
		wr(12'h28a, 16'h00ff);
		rdc(12'h28a, 16'h0000);
		wr(12'h286, 16'h03ff); // all ten mask bits set
		rdc(12'h286, 16'h03ff);
		wr(12'h286, 16'h0000);
		rdc(12'h286, 16'h0000);
		wr(12'h286, 16'h02f8);
		// Address bit from control, then from data; late write overwrites
		wr(12'h280, 16'h0400);
		wr(12'h288, 16'h0055);
		rdc(12'h288, 16'h0155);
		wr(12'h282, 16'h0004);
		wr(12'h288, 16'h01aa);
		rdc(12'h288, 16'h01aa);
		wr(12'h288, 16'h0033);
		rdc(12'h288, 16'h0033);
		wr(12'h282, 16'h0000);
		for (int i = 0; i < 1000 && u_peer.got.size() < 2; i++) waitc(1);
		`check_eq(u_peer.got[0], 8'h55)
		`check_eq(u_peer.got[1], 8'h33)
		// Line idle during a frame, quiet line with data waiting
		wr(12'h290, 16'h0003);
		fork
			u_peer.send_frame(8'ha3, 1'b1);
			begin
				waitc(80 * DIV);
				rd(12'h284);
				`check_eq(v[0], 1'b0)
			end
		join
		waitc(6);
		rdc(12'h284, 16'h00c5);
		`check_eq(irq_req, 1'b0)
		waitc(700 * DIV);
		rdc(12'h284, 16'h00c7);
		rdc(12'h28a, 16'h00a3);
		rdc(12'h284, 16'h0047);
		wr(12'h284, 16'h03fd);
		rdc(12'h284, 16'h0045);
		// Second frame waiting keeps data ready
		u_peer.send_frame(8'h11, 1'b1);
		u_peer.send_frame(8'h22, 1'b1);
		waitc(6);
		rdc(12'h28a, 16'h0011);
		rd(12'h284);
		`check_eq(v[7], 1'b1)
		rdc(12'h28a, 16'h0022);
		rd(12'h284);
		`check_eq(v[7], 1'b0)
		// Framing fault holds back DMA until extended reads
		wr(12'h280, 16'h1000);
		u_peer.send_frame(8'h5a, 1'b0);
		waitc(6);
		`check_eq(rx_dma_req, 1'b0)
		`check_eq(irq_req, 1'b1)
		rd(12'h284);
		`check_eq(v[5], 1'b1)
		wr(12'h290, 16'h0001);
		waitc(3);
		`check_eq(irq_req, 1'b0)
		wr(12'h290, 16'h0003);
		wr(12'h282, 16'h0002);
		waitc(3);
		`check_eq(rx_dma_req, 1'b1)
		rdc(12'h28a, 16'he05a);
		rd(12'h28a);
		`check_eq(v & 16'hff00, 16'h4000)
		waitc(3);
		`check_eq(irq_req, 1'b1)
		wr(12'h284, 16'h03df);
		waitc(3);
		`check_eq(irq_req, 1'b0)
		// Third unread frame replaces the waiting one and marks overrun
		u_peer.send_frame(8'h01, 1'b1);
		u_peer.send_frame(8'h02, 1'b1);
		u_peer.send_frame(8'h03, 1'b1);
		waitc(6);
		`check_eq(irq_req, 1'b1)
		rdc(12'h28a, 16'hc001);
		rdc(12'h28a, 16'hd003);
		rdc(12'h284, 16'h0055);
		wr(12'h284, 16'h03ef);
		rdc(12'h284, 16'h0045);
		wrap_up();
	end
endmodule
`default_nettype wire
